// file: fcor_defs.svh
/*
 * register offsets, field positions, reset values and timing figures
 * for the fan critical override and ramp block.
 * assumes a 200 MHz core clock and byte-wide registers.
 */
`ifndef FCOR_DEFS_SVH
`define FCOR_DEFS_SVH

`define FCOR_A_RAMPCFG      8'h10
`define FCOR_A_FLOOR_R1     8'h62
`define FCOR_A_LOC_R2       8'h63
`define FCOR_A_LIM_R1       8'h6A
`define FCOR_A_LIM_LOC      8'h6B
`define FCOR_A_LIM_R2       8'h6C
`define FCOR_A_HYST_R1L     8'h6D
`define FCOR_A_HYST_R2      8'h6E
`define FCOR_A_CHAIN        8'h6F
`define FCOR_A_DETECT       8'h73

`define FCOR_RST_RAMPCFG    8'h00
`define FCOR_RST_FLOOR_R1   8'h00
`define FCOR_RST_LOC_R2     8'h00
`define FCOR_RST_LIMIT      8'h64
`define FCOR_RST_HYST_R1L   8'h44
`define FCOR_RST_HYST_R2    8'h40
`define FCOR_RST_CHAIN      8'h00
`define FCOR_RST_DETECT     8'h00

`define FCOR_B_EXT          7
`define FCOR_B_FLOOR1       5
`define FCOR_B_DET_START    0
`define FCOR_B_CHAIN        0
`define FCOR_MSK_LOC_R2     8'h77
`define FCOR_MSK_HYST_R2    8'hF0
`define FCOR_MSK_CHAIN      8'h01

`define FCOR_FULL           8'hFF
`define FCOR_OFF            8'h00
`define FCOR_SLOW_MUL       4
// step interval in ticks per ramp code, code 7 first
`define FCOR_RAMP_STD       {12'h008, 12'h010, 12'h01F, 12'h02F, \
                             12'h04B, 12'h07D, 12'h0BC, 12'h177}
`define FCOR_RAMP_EXT       {12'h00B, 12'h016, 12'h02C, 12'h041, \
                             12'h068, 12'h0AE, 12'h105, 12'h20A}

`define FCOR_CLK_MHZ        200
`define FCOR_DET_TIME_US    5000
`define FCOR_TICK_TIME_NS   392157

`endif

// file: fcor_pkg.sv
/*
 * types of the fan critical override and ramp block.
 * assumes nothing beyond the defines header.
 */
`default_nettype none
package fcor_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fcor_req_t;

    typedef enum logic [0:0] {
        FCOR_DET_IDLE,
        FCOR_DET_SINK
    } fcor_det_t;
endpackage
`default_nettype wire

// file: fcor_top.sv
/*
 * fan critical override and ramp shaping for three pwm outputs.
 * assumes temperatures, start temperatures, curve duty and minimum duty
 * come from the curve and adc logic, synchronous to clk; out n follows
 * temperature channel n (remote one, local, remote two).
 */
`default_nettype none
`include "fcor_defs.svh"

// Summary of operation
// - any channel over limit forces full duty
// - hold full until below limit minus hysteresis
// - hysteresis fields reset to four degrees
// - override ignores automatic loop configuration
// - three critical limits reset to 100 degrees
// - hysteresis nibbles in two documented registers
// - hysteresis zero removes hysteresis entirely
// - same hysteresis for fan-off and override
// - floor bit selects off or minimum duty
// - floor kept means no fan-off hysteresis; the code still applies it before dropping to minimum duty
// - per-channel slow bit ramps four times slower
// - extended bit lengthens all ramps 39.2 percent
// - remote one ramp select, eight time steps
// - local and remote two ramp selects
// - extended ramp table, slow still divides four
// - detect enables sinks, reports presence bits
// - low core supply flags and stops pin monitoring
// - supply recovery re-enables monitoring
// - chain bit enters continuity test mode
// - power-up: monitoring off, outputs full
module fcor_top
    import fcor_pkg::*;
#(
    parameter int NCH      = 3,
    parameter int DET_CYC  = `FCOR_DET_TIME_US * `FCOR_CLK_MHZ,
    parameter int TICK_CYC = `FCOR_TICK_TIME_NS * `FCOR_CLK_MHZ / 1000
)(
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire fcor_req_t     req,
    output logic [7:0]         rdata,
    input  wire logic [7:0]    temp [NCH],
    input  wire logic          temp_valid,
    input  wire logic [7:0]    start_temp [NCH],
    input  wire logic [7:0]    curve_duty [NCH],
    input  wire logic [7:0]    min_duty [NCH],
    input  wire logic          monitor_en,
    input  wire logic          core_supply_low,
    input  wire logic          alert_en,
    input  wire logic [NCH-1:0] fan_sense,
    output logic [7:0]         duty [NCH],
    output logic [NCH-1:0]     sink_en,
    output logic               supply_low_flag,
    output logic               smbalert_n,
    output logic               critical_temp_pin_mon_en,
    output logic               continuity_chain_en
);

    if (NCH != 3 || DET_CYC < 2 || TICK_CYC < 2)
        $error("fcor_top: unsupported parameters");

    ////////////////////////////////////////////////////////////////////
    // helpers

    // limit minus hysteresis, floored at zero; a zero result can never be undercut, so release is then unreachable
    function automatic logic [7:0] sub_sat(input logic [7:0] a, input logic [3:0] h);
        sub_sat = (a > {4'h0, h}) ? a - {4'h0, h} : 8'h00;
    endfunction

    // ramp step interval in ticks; tick is one 255th of 0.1 s
    function automatic logic [11:0] ramp_ticks(input logic [2:0] code, input logic ext,
                                               input logic slow);
        logic [7:0][11:0] std_t;
        logic [7:0][11:0] ext_t;
        logic [11:0]      t;
        std_t = `FCOR_RAMP_STD;
        ext_t = `FCOR_RAMP_EXT;
        t = ext ? ext_t[code] : std_t[code];
        ramp_ticks = slow ? 12'(t * `FCOR_SLOW_MUL) : t;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] rampcfg_r, rampcfg_nxt;
    logic [7:0] floor_r, floor_nxt;
    logic [7:0] locr2_r, locr2_nxt;
    logic [7:0] lim_r [NCH], lim_nxt [NCH];
    logic [7:0] hyst1l_r, hyst1l_nxt;
    logic [7:0] hyst2_r, hyst2_nxt;
    logic [7:0] chain_r, chain_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       det_go_r, det_go_nxt;
    logic [NCH-1:0] present_r, present_nxt;
    fcor_det_t  det_r, det_nxt;
    logic [31:0] det_cnt_r, det_cnt_nxt;
    logic       det_done;
    logic [3:0] hyst [NCH];
    logic [2:0] rsel [NCH];

    assign hyst[0] = hyst1l_r[7:4];
    assign hyst[1] = hyst1l_r[3:0];
    assign hyst[2] = hyst2_r[7:4];
    assign rsel[0] = floor_r[2:0];
    assign rsel[1] = locr2_r[2:0];
    assign rsel[2] = locr2_r[6:4];
    assign det_done = (det_r == FCOR_DET_SINK) && (det_cnt_r == 32'(DET_CYC - 1));

    always_comb
    begin
        rampcfg_nxt = rampcfg_r;
        floor_nxt   = floor_r;
        locr2_nxt   = locr2_r;
        lim_nxt     = lim_r;
        hyst1l_nxt  = hyst1l_r;
        hyst2_nxt   = hyst2_r;
        chain_nxt   = chain_r;
        det_go_nxt  = 1'b0;
        rdata_nxt   = rdata_r;
        if (req.wr)
        begin
            case (req.addr)
                `FCOR_A_RAMPCFG:  rampcfg_nxt = req.wdata;
                `FCOR_A_FLOOR_R1: floor_nxt   = req.wdata;
                `FCOR_A_LOC_R2:   locr2_nxt   = req.wdata & `FCOR_MSK_LOC_R2;
                `FCOR_A_LIM_R1:   lim_nxt[0]  = req.wdata;
                `FCOR_A_LIM_LOC:  lim_nxt[1]  = req.wdata;
                `FCOR_A_LIM_R2:   lim_nxt[2]  = req.wdata;
                `FCOR_A_HYST_R1L: hyst1l_nxt  = req.wdata;
                `FCOR_A_HYST_R2:  hyst2_nxt   = req.wdata & `FCOR_MSK_HYST_R2;
                `FCOR_A_CHAIN:    chain_nxt   = req.wdata & `FCOR_MSK_CHAIN;
                `FCOR_A_DETECT:   det_go_nxt  = req.wdata[`FCOR_B_DET_START];
                default: ;
            endcase
        end
        if (req.rd)
        begin
            case (req.addr)
                `FCOR_A_RAMPCFG:  rdata_nxt = rampcfg_r;
                `FCOR_A_FLOOR_R1: rdata_nxt = floor_r;
                `FCOR_A_LOC_R2:   rdata_nxt = locr2_r;
                `FCOR_A_LIM_R1:   rdata_nxt = lim_r[0];
                `FCOR_A_LIM_LOC:  rdata_nxt = lim_r[1];
                `FCOR_A_LIM_R2:   rdata_nxt = lim_r[2];
                `FCOR_A_HYST_R1L: rdata_nxt = hyst1l_r;
                `FCOR_A_HYST_R2:  rdata_nxt = hyst2_r;
                `FCOR_A_CHAIN:    rdata_nxt = chain_r;
                `FCOR_A_DETECT:   rdata_nxt = {4'h0, present_r, det_r == FCOR_DET_SINK};
                default:          rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rampcfg_r <= `FCOR_RST_RAMPCFG;
            floor_r   <= `FCOR_RST_FLOOR_R1;
            locr2_r   <= `FCOR_RST_LOC_R2;
            lim_r     <= '{default: `FCOR_RST_LIMIT};
            hyst1l_r  <= `FCOR_RST_HYST_R1L;
            hyst2_r   <= `FCOR_RST_HYST_R2;
            chain_r   <= `FCOR_RST_CHAIN;
            det_go_r  <= 1'b0;
            rdata_r   <= 8'h00;
        end
        else
        begin
            rampcfg_r <= rampcfg_nxt;
            floor_r   <= floor_nxt;
            locr2_r   <= locr2_nxt;
            lim_r     <= lim_nxt;
            hyst1l_r  <= hyst1l_nxt;
            hyst2_r   <= hyst2_nxt;
            chain_r   <= chain_nxt;
            det_go_r  <= det_go_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;
    assign continuity_chain_en = chain_r[`FCOR_B_CHAIN];

    ////////////////////////////////////////////////////////////////////
    // fan presence detect

    always_comb
    begin
        det_nxt     = det_r;
        det_cnt_nxt = det_cnt_r;
        present_nxt = present_r;
        case (det_r)
            FCOR_DET_IDLE:
            begin
                det_cnt_nxt = 32'h0;
                if (det_go_r)
                    det_nxt = FCOR_DET_SINK;
            end
            FCOR_DET_SINK:
            begin
                det_cnt_nxt = det_cnt_r + 32'h1;
                if (det_done)
                begin
                    present_nxt = fan_sense;
                    det_nxt     = FCOR_DET_IDLE;
                end
            end
            default: det_nxt = FCOR_DET_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            det_r     <= FCOR_DET_IDLE;
            det_cnt_r <= 32'h0;
            present_r <= '0;
        end
        else
        begin
            det_r     <= det_nxt;
            det_cnt_r <= det_cnt_nxt;
            present_r <= present_nxt;
        end
    end

    // sinks stay on for the whole window; pwm level is software's job
    assign sink_en = {NCH{det_r == FCOR_DET_SINK}};

    ////////////////////////////////////////////////////////////////////
    // core supply standby

    logic sup_r, sup_nxt;
    assign sup_nxt = core_supply_low;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sup_r <= 1'b0;
        else
            sup_r <= sup_nxt;
    end

    assign supply_low_flag = sup_r;
    assign smbalert_n = !(sup_r && alert_en);
    // timer lives outside; it only loses its enable, so it keeps its count
    assign critical_temp_pin_mon_en = monitor_en && !sup_r;

    ////////////////////////////////////////////////////////////////////
    // critical override, fan-off state and ramp

    logic [NCH-1:0] crit_r, crit_nxt;
    logic [NCH-1:0] run_r, run_nxt;
    logic [7:0]     duty_r [NCH], duty_nxt [NCH];
    logic [11:0]    rcnt_r [NCH], rcnt_nxt [NCH];
    logic [7:0]     target [NCH];
    logic [31:0]    tick_cnt_r, tick_cnt_nxt;
    logic           tick, any_crit, forced;

    assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));
    assign tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
    assign any_crit = |crit_r;
    assign forced = any_crit || !monitor_en;

    always_comb
    begin
        crit_nxt = crit_r;
        run_nxt  = run_r;
        for (int i = 0; i < NCH; i++)
        begin
            if (temp_valid)
            begin
                if (temp[i] > lim_r[i])
                    crit_nxt[i] = 1'b1;
                else if (temp[i] < sub_sat(lim_r[i], hyst[i]))
                    crit_nxt[i] = 1'b0;
                if (temp[i] >= start_temp[i])
                    run_nxt[i] = 1'b1;
                else if (temp[i] < sub_sat(start_temp[i], hyst[i]))
                    run_nxt[i] = 1'b0;
            end
            if (!monitor_en)
            begin
                crit_nxt[i] = 1'b0;
                run_nxt[i]  = 1'b0;
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (run_r[i])
                target[i] = curve_duty[i];
            else if (floor_r[`FCOR_B_FLOOR1 + i])
                target[i] = min_duty[i];
            else
                target[i] = `FCOR_OFF;
            duty_nxt[i] = duty_r[i];
            rcnt_nxt[i] = rcnt_r[i];
            if (forced)
            begin
                duty_nxt[i] = `FCOR_FULL;
                rcnt_nxt[i] = 12'h000;
            end
            else if (tick)
            begin
                if (rcnt_r[i] + 12'h001 >= ramp_ticks(rsel[i], rampcfg_r[`FCOR_B_EXT],
                                                      rampcfg_r[i]))
                begin
                    rcnt_nxt[i] = 12'h000;
                    if (duty_r[i] < target[i])
                        duty_nxt[i] = duty_r[i] + 8'h01;
                    else if (duty_r[i] > target[i])
                        duty_nxt[i] = duty_r[i] - 8'h01;
                end
                else
                    rcnt_nxt[i] = rcnt_r[i] + 12'h001;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            crit_r     <= '0;
            run_r      <= '0;
            duty_r     <= '{default: `FCOR_FULL};
            rcnt_r     <= '{default: 12'h000};
            tick_cnt_r <= 32'h0;
        end
        else
        begin
            crit_r     <= crit_nxt;
            run_r      <= run_nxt;
            duty_r     <= duty_nxt;
            rcnt_r     <= rcnt_nxt;
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    assign duty = duty_r;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb_chk @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_crit_set;
        temp_valid && monitor_en && temp[0] > lim_r[0] |=> crit_r[0];
    endproperty
    a_crit_set: assert property (p_crit_set) else $error("critical not set");
    property p_crit_full;
        any_crit |=> duty_r[0] == `FCOR_FULL && duty_r[1] == `FCOR_FULL && duty_r[2] == `FCOR_FULL;
    endproperty
    a_crit_full: assert property (p_crit_full) else $error("override not full");
    property p_crit_hold;
        crit_r[1] && monitor_en && !(temp_valid && temp[1] < sub_sat(lim_r[1], hyst[1]))
        |=> crit_r[1];
    endproperty
    a_crit_hold: assert property (p_crit_hold) else $error("critical released early");
    property p_por_full;
        !monitor_en [*2] |-> duty_r[2] == `FCOR_FULL;
    endproperty
    a_por_full: assert property (p_por_full) else $error("idle duty not full");
    property p_ramp_step;
        !forced && $past(!forced) && $changed(duty_r[0])
        |-> $past(tick) && (duty_r[0] == $past(duty_r[0]) + 8'h01
                            || duty_r[0] == $past(duty_r[0]) - 8'h01);
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("duty jumped");
    property p_floor_off;
        !run_r[1] && !floor_r[`FCOR_B_FLOOR1 + 1] |-> target[1] == `FCOR_OFF;
    endproperty
    a_floor_off: assert property (p_floor_off) else $error("floor off wrong");
    property p_supply;
        core_supply_low |=> supply_low_flag && !critical_temp_pin_mon_en;
    endproperty
    a_supply: assert property (p_supply) else $error("standby not entered");
    property p_detect;
        det_go_r && det_r == FCOR_DET_IDLE |=> (sink_en == '1) [*2];
    endproperty
    a_detect: assert property (p_detect) else $error("sink not enabled");

    c_crit:   cover property ($fell(crit_r[0]));
    c_ramp:   cover property (!forced ##1 $changed(duty_r[1]));
    c_detect: cover property (det_done);

endmodule // fcor_top
`default_nettype wire

// file: fcor_fan_model.sv
/*
 * behavioural model of three pwm fans on the block's outputs.
 * assumes sink_en from the block; present fans pull the pin high.
 */
`default_nettype none
module fcor_fan_model
#(
    parameter logic [2:0] PRESENT = 3'b101
)(
    input  wire logic       clk,
    input  wire logic [2:0] sink_en,
    output logic [2:0]      fan_sense
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] idle_r = 3'h2;
    // unsunk pins float, so show a pattern that moves every cycle
    always @(posedge clk)
    begin
        idle_r <= ~idle_r;
    end
    assign fan_sense = (sink_en & PRESENT) | (~sink_en & idle_r);
endmodule // fcor_fan_model
`default_nettype wire

// file: fcor_top_tb.sv
/*
 * self-checking bench: register access, override, ramp, detect, supply.
 * assumes the defines header, the package and small tick/detect counts.
 */
`default_nettype none
`include "fcor_defs.svh"
module fcor_top_tb
    import fcor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 4;
    localparam int DET  = 20;
    logic            clk = 1'b0;
    logic            nrst = 1'b0;
    fcor_req_t       req;
    logic [7:0]      rdata;
    logic [7:0]      temp [3];
    logic            temp_valid;
    logic [7:0]      start_temp [3];
    logic [7:0]      curve_duty [3];
    logic [7:0]      min_duty [3];
    logic            monitor_en;
    logic            core_supply_low;
    logic            alert_en;
    logic [2:0]      fan_sense;
    logic [7:0]      duty [3];
    logic [2:0]      sink_en;
    logic            supply_low_flag;
    logic            smbalert_n;
    logic            critical_temp_pin_mon_en;
    logic            continuity_chain_en;
    int              n_fail = 0;
    int              checked = 0;

    always #2.5 clk = ~clk;

    fcor_top #(.NCH(3), .DET_CYC(DET), .TICK_CYC(TICK)) i_fcor_top (
        .clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .temp(temp),
        .temp_valid(temp_valid), .start_temp(start_temp), .curve_duty(curve_duty),
        .min_duty(min_duty), .monitor_en(monitor_en), .core_supply_low(core_supply_low),
        .alert_en(alert_en), .fan_sense(fan_sense), .duty(duty), .sink_en(sink_en),
        .supply_low_flag(supply_low_flag), .smbalert_n(smbalert_n),
        .critical_temp_pin_mon_en(critical_temp_pin_mon_en),
        .continuity_chain_en(continuity_chain_en));

    fcor_fan_model #(.PRESENT(3'b101)) i_fcor_fan_model (
        .clk(clk), .sink_en(sink_en), .fan_sense(fan_sense));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk) #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk) #1;
        req = '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk) #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk) #1;
        req = '0;
        @(posedge clk) #1;
        v = rdata;
    endtask

    task automatic chkr(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    // one conversion result on channel 0, the others stay cool
    task automatic conv(input logic [7:0] t0);
        @(posedge clk) #1;
        temp[0] = t0;
        temp_valid = 1'b1;
        @(posedge clk) #1;
        temp_valid = 1'b0;
    endtask

    // second gap is measured, the first may start mid-interval
    task automatic gap(input int exp);
        logic [7:0] d0;
        int n;
        for (int k = 0; k < 2; k++)
        begin
            d0 = duty[0];
            n = 0;
            while (duty[0] === d0 && n < 1000)
            begin
                cyc(1);
                n++;
            end
        end
        chk(8'(n), 8'(exp));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] RA [11] = '{8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h10,
                                       8'h62, 8'h63, 8'h6F, 8'h73, 8'h55};
    localparam logic [7:0] RV [11] = '{8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00,
                                       8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    initial
    begin
        req = '0;
        temp = '{8'h20, 8'h20, 8'h20};
        temp_valid = 1'b0;
        start_temp = '{8'h30, 8'h30, 8'h30};
        curve_duty = '{8'h80, 8'h80, 8'h80};
        min_duty = '{8'h40, 8'h40, 8'h40};
        monitor_en = 1'b0;
        core_supply_low = 1'b0;
        alert_en = 1'b1;
        cyc(10);
        nrst = 1'b1;
        for (int i = 0; i < 3; i++)
            chk(duty[i], 8'hFF);
        chk(8'(critical_temp_pin_mon_en), 8'h00);
        for (int i = 0; i < 11; i++)
            chkr(RA[i], RV[i]);
        $display("test reset done");

        wr(8'h63, 8'hFF);
        chkr(8'h63, 8'h77);
        wr(8'h6E, 8'hFF);
        chkr(8'h6E, 8'hF0);
        wr(8'h6D, 8'h5A);
        chkr(8'h6D, 8'h5A);
        wr(8'h6F, 8'hFF);
        chkr(8'h6F, 8'h01);
        chk(8'(continuity_chain_en), 8'h01);
        wr(8'h6F, 8'h00);
        wr(8'h63, 8'h00);
        wr(8'h6E, 8'h40);
        wr(8'h6D, 8'h44);
        $display("test registers done");

        monitor_en = 1'b1;
        wr(8'h6A, 8'h50);
        wr(8'h62, 8'h07);
        wr(8'h63, 8'h77);
        // let every output ramp off full first, so the override has to act
        cyc(200);
        conv(8'h51);
        cyc(1);
        for (int i = 0; i < 3; i++)
            chk(duty[i], 8'hFF);
        wr(8'h10, 8'h00);
        conv(8'h4C);
        cyc(80);
        chk(duty[0], 8'hFF);
        conv(8'h4B);
        cyc(80);
        chk(8'(duty[0] !== 8'hFF), 8'h01);
        wr(8'h6D, 8'h04);
        conv(8'h51);
        conv(8'h4F);
        cyc(80);
        chk(8'(duty[0] !== 8'hFF), 8'h01);
        wr(8'h6D, 8'h44);
        $display("test override done");

        gap(8 * TICK);
        wr(8'h62, 8'h06);
        gap(16 * TICK);
        wr(8'h62, 8'h07);
        wr(8'h10, 8'h80);
        gap(11 * TICK);
        wr(8'h10, 8'h01);
        gap(32 * TICK);
        wr(8'h10, 8'h00);
        $display("test ramp done");

        wr(8'h62, 8'h27);
        conv(8'h20);
        cyc(9000);
        chk(duty[0], 8'h40);
        chk(duty[1], 8'h00);
        conv(8'h30);
        cyc(2300);
        chk(duty[0], 8'h80);
        conv(8'h2D);
        cyc(100);
        chk(duty[0], 8'h80);
        monitor_en = 1'b0;
        cyc(2);
        chk(duty[2], 8'hFF);
        $display("test floor done");

        wr(8'h73, 8'h01);
        cyc(1);
        chk(8'(sink_en), 8'h07);
        chkr(8'h73, 8'h01);
        cyc(DET + 4);
        chk(8'(sink_en), 8'h00);
        chkr(8'h73, 8'h0A);
        $display("test detect done");

        monitor_en = 1'b1;
        core_supply_low = 1'b1;
        cyc(2);
        chk({5'h00, supply_low_flag, smbalert_n, critical_temp_pin_mon_en}, 8'h04);
        alert_en = 1'b0;
        cyc(1);
        chk(8'(smbalert_n), 8'h01);
        alert_en = 1'b1;
        core_supply_low = 1'b0;
        cyc(2);
        chk({5'h00, supply_low_flag, smbalert_n, critical_temp_pin_mon_en}, 8'h03);
        $display("test supply done");
        complete_run();
    end

    initial
    begin
        #400us;
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        complete_run();
    end
endmodule // fcor_top_tb
`default_nettype wire
